// File: hw/cad_decode_map.vh
`ifndef CAD_DECODE_MAP_VH
`define CAD_DECODE_MAP_VH
// ************************************************************
// format identifiers (top bits of the instruction word)
// ************************************************************
`define CAD_SHIFT_TAG       3'h0
`define CAD_ADDSUB_TAG      5'h03
`define CAD_BYTEIMM_TAG     3'h1
`define CAD_PAIR_TAG        6'h10
// ************************************************************
// field positions
// ************************************************************
`define CAD_DEST_LSB        0
`define CAD_SRC_LSB         3
`define CAD_THIRD_LSB       6
`define CAD_SHAMT_LSB       6
`define CAD_PAIROP_LSB      6
`define CAD_OP2_LSB         11
`define CAD_BYTEREG_LSB     8
`define CAD_IMMFLAG_BIT     10
`define CAD_SUBFLAG_BIT     9
// ************************************************************
// shift kinds used by the shifter
// ************************************************************
`define CAD_SH_LEFT         2'h0
`define CAD_SH_RIGHT        2'h1
`define CAD_SH_ARITH        2'h2
`define CAD_SH_ROT          2'h3
// ************************************************************
// byte-immediate operation codes
// ************************************************************
`define CAD_BI_MOVE         2'h0
`define CAD_BI_CMP          2'h1
`define CAD_BI_ADD          2'h2
`define CAD_BI_SUB          2'h3
// ************************************************************
// register-pair operation codes
// ************************************************************
`define CAD_OP_AND          4'h0
`define CAD_OP_XOR          4'h1
`define CAD_OP_LSL          4'h2
`define CAD_OP_LSR          4'h3
`define CAD_OP_ASR          4'h4
`define CAD_OP_ADC          4'h5
`define CAD_OP_SBC          4'h6
`define CAD_OP_ROR          4'h7
`define CAD_OP_TEST         4'h8
`define CAD_OP_NEG          4'h9
`define CAD_OP_CMP          4'hA
`define CAD_OP_CMN          4'hB
`define CAD_OP_OR           4'hC
`define CAD_OP_MUL          4'hD
`define CAD_OP_ANDN         4'hE
`define CAD_OP_NOT          4'hF
// ************************************************************
// execution cycle counts (equal to the full-width equivalents) and the flag reset value
// ************************************************************
`define CAD_CYC_SIMPLE      3'h1
`define CAD_CYC_REGSHIFT    3'h2
`define CAD_FLAG_RESET      4'h0
`endif

// File: hw/cad_reg_file.v
`timescale 1ns/1ns
// low register bank: two registered read ports, one write port
module cad_reg_file #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,   // core clock
  input  wire             clkEn,      // freezes the bank while low
  input  wire [AW-1:0]    rdAddrA,    // read port a index
  input  wire [AW-1:0]    rdAddrB,    // read port b index
  output reg  [WIDTH-1:0] rdDataA,    // registered read data a
  output reg  [WIDTH-1:0] rdDataB,    // registered read data b
  input  wire             wrEn,       // write strobe
  input  wire [AW-1:0]    wrAddr,     // write index
  input  wire [WIDTH-1:0] wrData      // write data
);
  reg [WIDTH-1:0] bank [0:DEPTH-1];

  // no reset: contents are undefined until software writes them
  always @(posedge core_clk) begin
    if (clkEn) begin
      if (wrEn) begin
        bank[wrAddr] <= wrData;
      end
      rdDataA <= bank[rdAddrA];
      rdDataB <= bank[rdAddrB];
    end
  end
endmodule // cad_reg_file

// File: hw/cad_decode_core.v
`timescale 1ns/1ns
`include "cad_decode_map.vh"
module cad_decode_core (
  input  wire        core_clk,    // core clock, 250 MHz
  input  wire        sys_rst,     // asynchronous reset, active high
  input  wire        clkEn,       // freezes all state while low
  input  wire        instrValid,  // fetch offers an instruction
  input  wire [15:0] instrWord,   // compressed instruction word
  output reg         instrReady,  // decoder can take an instruction
  output reg         doneStrobe,  // instruction finished, one cycle
  output reg         illegalStrobe, // word outside the four formats
  output reg         wbValid,     // register write happened, one cycle
  output reg  [2:0]  wbIndex,     // register written
  output reg  [31:0] wbData,      // value written
  output reg         flagNeg,     // negative flag
  output reg         flagZero,    // zero flag
  output reg         flagCarry,   // carry flag
  output reg         flagOvf      // overflow flag
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_EXEC = 2'h2;

  // ************************************************************
  // shared arithmetic
  // ************************************************************
  // returns {carry, value}; amount 0 keeps the incoming carry
  function [32:0] shiftOp;
    input [1:0]  kind;
    input [7:0]  amt;
    input [31:0] val;
    input        cin;
    reg   [63:0] t;
    begin
      t = 64'h0;
      shiftOp = {cin, val};
      if (amt != 8'h00) begin
        case (kind)
          `CAD_SH_LEFT: begin
            t = {32'h0, val} << amt;
            shiftOp = {t[32], t[31:0]};
          end
          `CAD_SH_RIGHT: begin
            t = {val, 32'h0} >> amt;
            shiftOp = {t[31], t[63:32]};
          end
          `CAD_SH_ARITH: begin
            if (amt >= 8'h20) begin
              shiftOp = {val[31], {32{val[31]}}};
            end else begin
              t = $signed({val, 32'h0}) >>> amt;
              shiftOp = {t[31], t[63:32]};
            end
          end
          default: begin
            if (amt[4:0] == 5'h00) begin
              shiftOp = {val[31], val};
            end else begin
              t = {val, val} >> amt[4:0];
              shiftOp = {t[31], t[31:0]};
            end
          end
        endcase
      end
    end
  endfunction

  // returns {overflow, carry, sum}
  function [33:0] addOp;
    input [31:0] a;
    input [31:0] b;
    input        cin;
    reg   [32:0] s;
    begin
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      addOp = {(a[31] == b[31]) && (s[31] != a[31]), s};
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg  [1:0]  state;
  reg  [15:0] instr;
  reg  [2:0]  waitCnt;
  wire [31:0] opA;
  wire [31:0] opB;

  wire isAddSub = (instr[15:11] == `CAD_ADDSUB_TAG);
  wire isShift  = (instr[15:13] == `CAD_SHIFT_TAG) && !isAddSub;
  wire isByte   = (instr[15:13] == `CAD_BYTEIMM_TAG);
  wire isPair   = (instr[15:10] == `CAD_PAIR_TAG);
  wire [3:0] pairOp = instr[`CAD_PAIROP_LSB+3:`CAD_PAIROP_LSB];
  wire [1:0] op2    = instr[`CAD_OP2_LSB+1:`CAD_OP2_LSB];
  wire [2:0] dstIdx = instr[`CAD_DEST_LSB+2:`CAD_DEST_LSB];
  wire [2:0] srcIdx = instr[`CAD_SRC_LSB+2:`CAD_SRC_LSB];
  wire [2:0] thdIdx = instr[`CAD_THIRD_LSB+2:`CAD_THIRD_LSB];
  wire [2:0] bytIdx = instr[`CAD_BYTEREG_LSB+2:`CAD_BYTEREG_LSB];

  wire inFormat = (instrWord[15:13] == `CAD_SHIFT_TAG) ||
                  (instrWord[15:13] == `CAD_BYTEIMM_TAG) ||
                  (instrWord[15:10] == `CAD_PAIR_TAG);

  // first port reads the operand the result is built on
  wire [2:0] rdA = isByte ? bytIdx : (isPair ? dstIdx : srcIdx);
  wire [2:0] rdB = isPair ? srcIdx : thdIdx;

  // ************************************************************
  // execute
  // ************************************************************
  reg        next_wr;
  reg [2:0]  next_idx;
  reg [31:0] next_val;
  reg        next_c;
  reg        next_v;
  reg [2:0]  needCyc;
  reg [32:0] sh;
  reg [33:0] ar;
  reg [4:0]  amt5;

  always @* begin
    next_wr  = 1'b1;
    next_idx = dstIdx;
    next_val = 32'h0;
    next_c   = flagCarry;
    next_v   = flagOvf;
    needCyc  = `CAD_CYC_SIMPLE;
    sh       = 33'h0;
    ar       = 34'h0;
    amt5     = instr[`CAD_SHAMT_LSB+4:`CAD_SHAMT_LSB];
    if (isAddSub) begin
      // third operand register or zero-extended immediate
      if (instr[`CAD_SUBFLAG_BIT]) begin
        ar = addOp(opA, ~(instr[`CAD_IMMFLAG_BIT] ? {29'h0, thdIdx} : opB), 1'b1);
      end else begin
        ar = addOp(opA, instr[`CAD_IMMFLAG_BIT] ? {29'h0, thdIdx} : opB, 1'b0);
      end
      next_val = ar[31:0];
      next_c   = ar[32];
      next_v   = ar[33];
    end else if (isShift) begin
      // right shifts by an encoded zero mean a full 32-place shift
      if (op2 != `CAD_SH_LEFT && amt5 == 5'h00) begin
        sh = shiftOp(op2, 8'h20, opA, flagCarry);
      end else begin
        sh = shiftOp(op2, {3'h0, amt5}, opA, flagCarry);
      end
      next_val = sh[31:0];
      next_c   = sh[32];
    end else if (isByte) begin
      next_idx = bytIdx;
      case (op2)
        `CAD_BI_MOVE: next_val = {24'h0, instr[7:0]};
        `CAD_BI_ADD: ar = addOp(opA, {24'h0, instr[7:0]}, 1'b0);
        default: ar = addOp(opA, ~{24'h0, instr[7:0]}, 1'b1);
      endcase
      if (op2 != `CAD_BI_MOVE) begin
        next_val = ar[31:0];
        next_c   = ar[32];
        next_v   = ar[33];
      end
      next_wr = (op2 != `CAD_BI_CMP);
    end else begin
      case (pairOp)
        `CAD_OP_AND, `CAD_OP_TEST: next_val = opA & opB;
        `CAD_OP_XOR:  next_val = opA ^ opB;
        `CAD_OP_OR:   next_val = opA | opB;
        `CAD_OP_ANDN: next_val = opA & ~opB;
        `CAD_OP_NOT:  next_val = ~opB;
        `CAD_OP_LSL, `CAD_OP_LSR, `CAD_OP_ASR, `CAD_OP_ROR: begin
          // amount is the low byte of the source register
          sh = shiftOp((pairOp == `CAD_OP_LSL) ? `CAD_SH_LEFT :
                       (pairOp == `CAD_OP_LSR) ? `CAD_SH_RIGHT :
                       (pairOp == `CAD_OP_ASR) ? `CAD_SH_ARITH : `CAD_SH_ROT,
                       opB[7:0], opA, flagCarry);
          next_val = sh[31:0];
          next_c   = sh[32];
          needCyc  = `CAD_CYC_REGSHIFT;
        end
        `CAD_OP_MUL: begin
          next_val = opB * opA;
          // early termination on the multiplier's top bytes
          if (opB[31:8] == 24'h0 || opB[31:8] == 24'hFFFFFF) begin
            needCyc = 3'h2;
          end else if (opB[31:16] == 16'h0 || opB[31:16] == 16'hFFFF) begin
            needCyc = 3'h3;
          end else if (opB[31:24] == 8'h0 || opB[31:24] == 8'hFF) begin
            needCyc = 3'h4;
          end else begin
            needCyc = 3'h5;
          end
        end
        `CAD_OP_ADC, `CAD_OP_CMN: ar = addOp(opA, opB,
                                    (pairOp == `CAD_OP_ADC) & flagCarry);
        `CAD_OP_NEG: ar = addOp(32'h0, ~opB, 1'b1);
        default: ar = addOp(opA, ~opB,
                            (pairOp == `CAD_OP_SBC) ? flagCarry : 1'b1);
      endcase
      if (pairOp == `CAD_OP_ADC || pairOp == `CAD_OP_SBC || pairOp == `CAD_OP_NEG ||
          pairOp == `CAD_OP_CMP || pairOp == `CAD_OP_CMN) begin
        next_val = ar[31:0];
        next_c   = ar[32];
        next_v   = ar[33];
      end
      next_wr = !(pairOp == `CAD_OP_TEST || pairOp == `CAD_OP_CMP ||
                  pairOp == `CAD_OP_CMN);
    end
  end

  wire lastCyc = (state == ST_EXEC) && (waitCnt + 3'h1 >= needCyc);

  cad_reg_file #(
    .WIDTH (32),
    .DEPTH (8),
    .AW    (3)
  ) cad_reg_file_inst (
    .core_clk (core_clk),
    .clkEn    (clkEn),
    .rdAddrA  (rdA),
    .rdAddrB  (rdB),
    .rdDataA  (opA),
    .rdDataB  (opB),
    .wrEn     (lastCyc && next_wr),
    .wrAddr   (next_idx),
    .wrData   (next_val)
  );

  // ************************************************************
  // sequencing
  // ************************************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= ST_IDLE;
      instr         <= 16'h0000;
      waitCnt       <= 3'h0;
      instrReady    <= 1'b0;
      doneStrobe    <= 1'b0;
      illegalStrobe <= 1'b0;
      wbValid       <= 1'b0;
      wbIndex       <= 3'h0;
      wbData        <= 32'h0;
      {flagNeg, flagZero, flagCarry, flagOvf} <= `CAD_FLAG_RESET;
    end else if (clkEn) begin
      doneStrobe    <= 1'b0;
      illegalStrobe <= 1'b0;
      wbValid       <= 1'b0;
      case (state)
        ST_IDLE: begin
          instrReady <= 1'b1;
          if (instrValid && instrReady) begin
            if (inFormat) begin
              instr      <= instrWord;
              instrReady <= 1'b0;
              state      <= ST_READ;
            end else begin
              illegalStrobe <= 1'b1;
            end
          end
        end
        ST_READ: begin
          waitCnt <= 3'h0;
          state   <= ST_EXEC;
        end
        ST_EXEC: begin
          waitCnt <= waitCnt + 3'h1;
          if (lastCyc) begin
            flagNeg    <= next_val[31];
            flagZero   <= (next_val == 32'h0);
            flagCarry  <= next_c;
            flagOvf    <= next_v;
            wbValid    <= next_wr;
            wbIndex    <= next_idx;
            wbData     <= next_val;
            doneStrobe <= 1'b1;
            instrReady <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // cad_decode_core

// File: tb/cad_decode_sva.sv
`timescale 1ns/1ns
module cad_decode_sva (
  input wire logic        core_clk,      // core clock
  input wire logic        sys_rst,       // async reset
  input wire logic        clkEn,         // clock enable
  input wire logic        instrValid,    // fetch offers a word
  input wire logic [15:0] instrWord,     // offered word
  input wire logic        instrReady,    // decoder accepts
  input wire logic        doneStrobe,    // completion pulse
  input wire logic        illegalStrobe, // unknown word pulse
  input wire logic        wbValid,       // write-back pulse
  input wire logic [2:0]  wbIndex,       // register written
  input wire logic [31:0] wbData,        // result
  input wire logic        flagNeg,       // negative flag
  input wire logic        flagZero,      // zero flag
  input wire logic        flagCarry,     // carry flag
  input wire logic        flagOvf        // overflow flag
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire       take     = instrValid && instrReady && clkEn;
  wire       pairW    = instrWord[15:10] == 6'h10;
  wire [3:0] pOp      = instrWord[9:6];
  wire       legal    = (instrWord[15:14] == 2'h0) || pairW;
  wire       pairMul  = pairW && (pOp == 4'hD);
  wire       pairSlow = pairW && (pOp inside {4'h2, 4'h3, 4'h4, 4'h7});
  wire       flagOnly = (instrWord[15:11] == 5'h05) || (pairW && (pOp inside {4'h8, 4'hA, 4'hB}));
  reg  [2:0] takenDest;
  reg        takenMove;
  reg  [7:0] takenImm;
  // destination is latched at the take edge since the word is gone by completion
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      takenDest <= 3'h0;
      takenMove <= 1'b0;
      takenImm  <= 8'h00;
    end else if (take && legal) begin
      takenDest <= (instrWord[15:13] == 3'h1) ? instrWord[10:8] : instrWord[2:0];
      takenMove <= instrWord[15:11] == 5'h04;
      takenImm  <= instrWord[7:0];
    end
  end
  a_take_busy: assert property (take && legal |=> !instrReady)
    else $error("decoder still ready after taking a word");
  a_illegal_pulse: assert property (take && !legal |=> illegalStrobe && instrReady)
    else $error("unknown word not flagged");
  a_fast_done: assert property ((take && legal && !pairSlow && !pairMul) ##1 clkEn [*2] |=> doneStrobe)
    else $error("single cycle op did not complete on time");
  a_slow_early: assert property ((take && pairSlow) ##1 clkEn [*2] |=> !doneStrobe)
    else $error("register shift completed too early");
  a_slow_done: assert property ((take && pairSlow) ##1 clkEn [*3] |=> doneStrobe)
    else $error("register shift did not complete on time");
  a_flag_only: assert property ((take && flagOnly) ##1 clkEn [*2] |=> doneStrobe && !wbValid)
    else $error("flag-only op wrote a register");
  a_wb_pulse: assert property (wbValid |-> doneStrobe)
    else $error("write-back without completion");
  a_wb_dest: assert property (wbValid |-> wbIndex == takenDest)
    else $error("write-back to wrong register");
  a_move_data: assert property (doneStrobe && takenMove |->
    wbData == {24'h000000, takenImm} && flagZero == (takenImm == 8'h00) && !flagNeg)
    else $error("byte move result or flags wrong");
  a_flags_hold: assert property (!$stable({flagNeg, flagZero, flagCarry, flagOvf}) |-> doneStrobe)
    else $error("flags changed without completion");
endmodule  // cad_decode_sva
bind cad_decode_core cad_decode_sva cad_decode_sva_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .instrValid(instrValid),
  .instrWord(instrWord), .instrReady(instrReady), .doneStrobe(doneStrobe),
  .illegalStrobe(illegalStrobe), .wbValid(wbValid), .wbIndex(wbIndex), .wbData(wbData),
  .flagNeg(flagNeg), .flagZero(flagZero), .flagCarry(flagCarry), .flagOvf(flagOvf));

// File: tb/cad_fetch_model.sv
`timescale 1ns/1ns
module cad_fetch_model (
  input  wire logic        core_clk,   // core clock
  input  wire logic        sys_rst,    // async reset
  input  wire logic        clkEn,      // clock enable
  input  wire logic        instrReady, // decoder accepts
  output logic             instrValid, // word offered
  output logic [15:0]      instrWord   // offered word
);
  // ************************************************************
  // fetch stage: holds an offer until the decoder takes it
  // ************************************************************
  logic        pend = 1'b0;
  logic [15:0] pendWord;
  task automatic push(input logic [15:0] w);
    pendWord = w;
    pend = 1'b1;
  endtask
  always @(posedge core_clk) begin
    if (instrValid && instrReady && clkEn) begin
      pend <= 1'b0;
    end
  end
  // idle word toggles so that a decoder reading it unqualified sees garbage
  always @(negedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      instrValid <= 1'b0;
      instrWord  <= 16'hFFFF;
    end else if (pend) begin
      instrValid <= 1'b1;
      instrWord  <= pendWord;
    end else begin
      instrValid <= 1'b0;
      instrWord  <= ~instrWord;
    end
  end
endmodule  // cad_fetch_model

// File: tb/compact_alu_instr_decode_bench.sv
`timescale 1ns/1ns
module compact_alu_instr_decode_bench;
  // ************************************************************
  // stimulus and scoring
  // ************************************************************
  logic        core_clk, sys_rst, clkEn, instrValid, instrReady, doneStrobe, illegalStrobe;
  logic        wbValid, flagNeg, flagZero, flagCarry, flagOvf;
  logic [15:0] instrWord;
  logic [2:0]  wbIndex;
  logic [31:0] wbData;
  int          bad_count, samples_checked, cycleCount;
  // pair results for destination 0xB5, source 3, carry set
  logic [31:0] pairExp [16] = '{32'h1, 32'hB6, 32'h5A8, 32'h16, 32'h16, 32'hB9, 32'hB2,
    32'hA0000016, 32'h1, 32'hFFFFFFFD, 32'hB2, 32'hB8, 32'hB7, 32'h21F, 32'hB4, 32'hFFFFFFFC};
  cad_decode_core cad_decode_core_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady),
    .doneStrobe(doneStrobe), .illegalStrobe(illegalStrobe), .wbValid(wbValid),
    .wbIndex(wbIndex), .wbData(wbData), .flagNeg(flagNeg), .flagZero(flagZero),
    .flagCarry(flagCarry), .flagOvf(flagOvf));
  cad_fetch_model cad_fetch_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .instrReady(instrReady), .instrValid(instrValid), .instrWord(instrWord));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check_value(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_flag(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  // count falls from the offer to completion; single-cycle ops take four
  task automatic exec(input logic [15:0] w);
    cycleCount = 0;
    @(posedge core_clk);
    cad_fetch_model_inst.push(w);
    do begin
      @(negedge core_clk);
      cycleCount++;
    end while (doneStrobe !== 1'b1 && illegalStrobe !== 1'b1 && cycleCount < 20);
    if (cycleCount >= 20) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic run_op(input logic [15:0] w, input logic [31:0] expData, input logic expWb,
                        input int expCycles);
    exec(w);
    check_value("cycles", expCycles, cycleCount);
    check_flag("wbValid", expWb, wbValid);
    check_value("wbData", expData, wbData);
    check_flag("flagZero", expData == 32'h0, flagZero);
    check_flag("flagNeg", expData[31], flagNeg);
  endtask
  task automatic load(input logic [2:0] r, input logic [7:0] v);
    run_op({5'h04, r, v}, {24'h000000, v}, 1'b1, 4);
    check_value("wbIndex", {29'h0, r}, {29'h0, wbIndex});
  endtask
  task automatic t_byte_imm();
    for (int i = 0; i < 8; i++) begin
      load(i[2:0], 8'h10 + i[7:0]);
    end
    load(3'h5, 8'h00);
    run_op({5'h05, 3'h1, 8'h11}, 32'h0, 1'b0, 4);
    check_flag("flagCarry", 1'b1, flagCarry);
    run_op({5'h06, 3'h2, 8'hF0}, 32'h102, 1'b1, 4);
    run_op({5'h07, 3'h3, 8'h14}, 32'hFFFFFFFF, 1'b1, 4);
    check_flag("flagCarry", 1'b0, flagCarry);
    $display("test byte_imm done");
  endtask
  task automatic t_shift_imm();
    load(3'h1, 8'h81);
    run_op({5'h00, 5'h18, 3'h1, 3'h2}, 32'h81000000, 1'b1, 4);
    run_op({5'h01, 5'h04, 3'h2, 3'h3}, 32'h08100000, 1'b1, 4);
    run_op({5'h02, 5'h04, 3'h2, 3'h4}, 32'hF8100000, 1'b1, 4);
    check_value("wbIndex", 32'h4, {29'h0, wbIndex});
    $display("test shift_imm done");
  endtask
  task automatic t_add_sub();
    load(3'h1, 8'hC8);
    load(3'h2, 8'h64);
    run_op({5'h03, 2'h0, 3'h2, 3'h1, 3'h3}, 32'h12C, 1'b1, 4);
    run_op({5'h03, 2'h2, 3'h7, 3'h1, 3'h4}, 32'hCF, 1'b1, 4);
    run_op({5'h03, 2'h1, 3'h1, 3'h2, 3'h5}, 32'hFFFFFF9C, 1'b1, 4);
    run_op({5'h03, 2'h3, 3'h7, 3'h2, 3'h6}, 32'h5D, 1'b1, 4);
    $display("test add_sub done");
  endtask
  task automatic t_pair();
    logic wr;
    int   cyc;
    for (int op = 0; op < 16; op++) begin
      load(3'h6, 8'hB5);
      load(3'h7, 8'h03);
      run_op({5'h05, 3'h7, 8'h03}, 32'h0, 1'b0, 4);
      wr = !(op inside {8, 10, 11});
      cyc = (op inside {2, 3, 4, 7, 13}) ? 5 : 4;
      run_op({6'h10, op[3:0], 3'h7, 3'h6}, pairExp[op], wr, cyc);
      check_flag("flagOvf", 1'b0, flagOvf);
    end
    $display("test pair done");
  endtask
  // clock enable low for three edges after the take must stretch the op by three
  task automatic t_stall();
    load(3'h1, 8'h05);
    fork
      run_op({5'h03, 2'h2, 3'h2, 3'h1, 3'h0}, 32'h7, 1'b1, 7);
      begin
        repeat (2) @(negedge core_clk);
        clkEn = 1'b0;
        repeat (3) @(negedge core_clk);
        clkEn = 1'b1;
      end
    join
    check_value("wbIndex", 32'h0, {29'h0, wbIndex});
    $display("test stall done");
  endtask
  task automatic t_illegal();
    logic [15:0] words [2] = '{16'h4400, 16'hE000};
    for (int i = 0; i < 2; i++) begin
      exec(words[i]);
      check_flag("illegalStrobe", 1'b1, illegalStrobe);
      check_flag("doneStrobe", 1'b0, doneStrobe);
      check_value("cycles", 32'h2, cycleCount);
    end
    $display("test illegal done");
  endtask
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
    t_byte_imm();
    t_shift_imm();
    t_add_sub();
    t_pair();
    t_stall();
    t_illegal();
    complete_run();
  end
endmodule  // compact_alu_instr_decode_bench
